// file: core/amp_control_port_state.sv
// Purpose: i2c target port, paged registers, power state, pwm, load detect
// Assumes: strap pin already decoded to two bits by the analog front end
// Notes: scl is sampled, never used as a clock
`timescale 1ns/10ps
`include "amp_ctrl_map.svh"
module amp_control_port_state #(
  parameter int unsigned LOAD_DETECT_CYCLES = `LOAD_DETECT_CYCLES
) (
  // system
  input wire logic clk_sys,
  input wire logic reset_n,
  // device pins
  input wire logic power_down_pin_n,
  input wire logic [1:0] addr_strap,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // load comparators, one bit per channel
  input wire logic [1:0] load_short_flag,
  input wire logic [1:0] load_open_flag,
  // audio levels, channel 1 in the low byte, and supply code
  input wire logic [15:0] audio_level,
  input wire logic [7:0] power_stage_supply,
  // power domains
  output logic digital_ldo_en,
  output logic analog_ldo_en,
  output logic dsp_active,
  // output stage
  output logic output_stage_hiz,
  output logic [1:0] positive_output_leg,
  output logic [1:0] negative_output_leg
);

  localparam logic [21:0] LD_LAST = 22'(LOAD_DETECT_CYCLES - 1);

  logic [8:0] sync_v, prev_v;
  pin_sync #(.WIDTH(9)) u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .pin_in({power_down_pin_n, addr_strap, load_short_flag,
             load_open_flag, scl_in, sda_in}),
    .pin_sync(sync_v),
    .pin_prev(prev_v)
  );

  logic pdn_ok, scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
  logic [1:0] strap_s, short_s, open_s;
  assign pdn_ok = sync_v[8];
  assign strap_s = sync_v[7:6];
  assign short_s = sync_v[5:4];
  assign open_s = sync_v[3:2];
  assign scl_s = sync_v[1];
  assign sda_s = sync_v[0];
  assign scl_rise = scl_s & ~prev_v[1];
  assign scl_fall = ~scl_s & prev_v[1];
  assign start_det = scl_s & prev_v[1] & prev_v[0] & ~sda_s;
  assign stop_det = scl_s & prev_v[1] & ~prev_v[0] & sda_s;

  // register state
  logic [7:0] page_r, page_nxt, book_r, book_nxt, mod_r, mod_nxt;
  logic [7:0] ost_r, ost_nxt, pst_r, pst_nxt, open_en_r, open_en_nxt;
  logic [7:0] short_en_r, short_en_nxt, cfg_r, cfg_nxt, status_r;
  amp_ctrl_pkg::power_state_t state_r, state_nxt;
  logic [1:0] strap_r, strap_nxt;
  logic strap_ok_r, strap_ok_nxt;
  logic on_p0, on_b0p0, wr_en, ld_rearm;
  logic [7:0] wr_addr, wr_data, rd_byte;
  logic [7:0] sub_r, sub_nxt;

  assign on_p0 = (page_r == 8'h00);
  assign on_b0p0 = on_p0 && (book_r == 8'h00);

  // unmapped locations read zero
  always_comb begin
    rd_byte = 8'h00;
    if (sub_r == `OFS_PAGE_SELECT) rd_byte = page_r;
    else if (on_p0 && sub_r == `OFS_BOOK_SELECT) rd_byte = book_r;
    else if (on_b0p0) begin
      unique case (sub_r)
        `OFS_MODULATION: rd_byte = mod_r;
        `OFS_OUTPUT_STATE: rd_byte = {ost_r[7:2], state_r};
        `OFS_POWER_STATE: rd_byte = {pst_r[7:2], state_r};
        `OFS_OPEN_LOAD_EN: rd_byte = open_en_r;
        `OFS_SHORT_LOAD_EN: rd_byte = short_en_r;
        `OFS_LOAD_CONFIG: rd_byte = cfg_r;
        `OFS_LOAD_STATUS: rd_byte = status_r;
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // i2c target engine
  amp_ctrl_pkg::i2c_state_t st_r, st_nxt, ret_r, ret_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [6:0] rx_r, rx_nxt;
  logic [7:0] tx_r, tx_nxt, rx_byte;
  logic drv_r, drv_nxt, ackph_r, ackph_nxt, acked_r, acked_nxt;

  assign rx_byte = {rx_r, sda_s};

  always_comb begin
    st_nxt = st_r;
    ret_nxt = ret_r;
    cnt_nxt = cnt_r;
    rx_nxt = rx_r;
    tx_nxt = tx_r;
    sub_nxt = sub_r;
    drv_nxt = drv_r;
    ackph_nxt = ackph_r;
    acked_nxt = acked_r;
    wr_en = 1'b0;
    wr_addr = sub_r;
    wr_data = rx_byte;
    if (!pdn_ok) begin
      st_nxt = amp_ctrl_pkg::I2C_IDLE;
      drv_nxt = 1'b0;
    end else if (start_det) begin
      st_nxt = amp_ctrl_pkg::I2C_ADDR;
      cnt_nxt = 3'h0;
      drv_nxt = 1'b0;
    end else if (stop_det) begin
      st_nxt = amp_ctrl_pkg::I2C_IDLE;
      drv_nxt = 1'b0;
    end else begin
      unique case (st_r)
        amp_ctrl_pkg::I2C_IDLE, amp_ctrl_pkg::I2C_IGNORE: begin
        end
        amp_ctrl_pkg::I2C_ADDR, amp_ctrl_pkg::I2C_SUB,
        amp_ctrl_pkg::I2C_WDATA: begin
          if (scl_rise) begin
            rx_nxt = rx_byte[6:0];
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == 3'h7) begin
              ackph_nxt = 1'b0;
              st_nxt = amp_ctrl_pkg::I2C_ACK;
              if (st_r == amp_ctrl_pkg::I2C_ADDR) begin
                if (rx_byte[7:1] != {`TARGET_ADDR_HI, strap_r})
                  st_nxt = amp_ctrl_pkg::I2C_IGNORE;
                else if (rx_byte[0])
                  ret_nxt = amp_ctrl_pkg::I2C_RDATA;
                else
                  ret_nxt = amp_ctrl_pkg::I2C_SUB;
              end else if (st_r == amp_ctrl_pkg::I2C_SUB) begin
                sub_nxt = rx_byte;
                ret_nxt = amp_ctrl_pkg::I2C_WDATA;
              end else begin
                wr_en = 1'b1;
                sub_nxt = sub_r + 8'h01;
                ret_nxt = amp_ctrl_pkg::I2C_WDATA;
              end
            end
          end
        end
        amp_ctrl_pkg::I2C_ACK: begin
          if (scl_fall) begin
            if (!ackph_r) begin
              drv_nxt = 1'b1;
              ackph_nxt = 1'b1;
            end else begin
              cnt_nxt = 3'h0;
              st_nxt = ret_r;
              drv_nxt = 1'b0;
              if (ret_r == amp_ctrl_pkg::I2C_RDATA) begin
                tx_nxt = rd_byte;
                drv_nxt = ~rd_byte[7];
              end
            end
          end
        end
        amp_ctrl_pkg::I2C_RDATA: begin
          if (scl_fall) begin
            if (cnt_r == 3'h7) begin
              drv_nxt = 1'b0;
              st_nxt = amp_ctrl_pkg::I2C_RACK;
            end else begin
              tx_nxt = {tx_r[6:0], 1'b0};
              drv_nxt = ~tx_r[6];
              cnt_nxt = cnt_r + 3'h1;
            end
          end
        end
        amp_ctrl_pkg::I2C_RACK: begin
          if (scl_rise) begin
            acked_nxt = ~sda_s;
            sub_nxt = sub_r + 8'h01;
          end else if (scl_fall) begin
            cnt_nxt = 3'h0;
            if (acked_r) begin
              tx_nxt = rd_byte;
              drv_nxt = ~rd_byte[7];
              st_nxt = amp_ctrl_pkg::I2C_RDATA;
            end else begin
              st_nxt = amp_ctrl_pkg::I2C_IGNORE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= amp_ctrl_pkg::I2C_IDLE;
      ret_r <= amp_ctrl_pkg::I2C_IDLE;
      cnt_r <= 3'h0;
      rx_r <= 7'h00;
      tx_r <= 8'h00;
      sub_r <= 8'h00;
      drv_r <= 1'b0;
      ackph_r <= 1'b0;
      acked_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      ret_r <= ret_nxt;
      cnt_r <= cnt_nxt;
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      sub_r <= sub_nxt;
      drv_r <= drv_nxt;
      ackph_r <= ackph_nxt;
      acked_r <= acked_nxt;
    end
  end

  // open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe_n = ~drv_r;

  // register file; strap caught once after reset and again after each power-down
  assign ld_rearm = wr_en && on_b0p0 && (wr_addr == `OFS_OPEN_LOAD_EN ||
    wr_addr == `OFS_SHORT_LOAD_EN || wr_addr == `OFS_LOAD_CONFIG);

  always_comb begin
    page_nxt = page_r;
    book_nxt = book_r;
    mod_nxt = mod_r;
    ost_nxt = ost_r;
    pst_nxt = pst_r;
    state_nxt = state_r;
    open_en_nxt = open_en_r;
    short_en_nxt = short_en_r;
    cfg_nxt = cfg_r;
    strap_nxt = strap_r;
    strap_ok_nxt = strap_ok_r;
    if (!pdn_ok) begin
      page_nxt = `RST_PAGE;
      book_nxt = `RST_BOOK;
      mod_nxt = `RST_MODULATION;
      ost_nxt = `RST_OUTPUT_STATE;
      pst_nxt = `RST_POWER_STATE;
      state_nxt = amp_ctrl_pkg::power_state_t'(2'(`RST_POWER_STATE));
      open_en_nxt = `RST_LOAD_REG;
      short_en_nxt = `RST_LOAD_REG;
      cfg_nxt = `RST_LOAD_REG;
      strap_ok_nxt = 1'b0;
    end else begin
      if (!strap_ok_r) begin
        strap_nxt = strap_s;
        strap_ok_nxt = 1'b1;
      end
      if (wr_en) begin
        if (wr_addr == `OFS_PAGE_SELECT) page_nxt = wr_data;
        else if (on_p0 && wr_addr == `OFS_BOOK_SELECT)
          book_nxt = wr_data;
        else if (on_b0p0) begin
          unique case (wr_addr)
            `OFS_MODULATION: mod_nxt = wr_data;
            `OFS_OUTPUT_STATE: begin
              ost_nxt = wr_data;
              state_nxt = amp_ctrl_pkg::power_state_t'(wr_data[`FLD_STATE]);
            end
            `OFS_POWER_STATE: begin
              pst_nxt = wr_data;
              state_nxt = amp_ctrl_pkg::power_state_t'(wr_data[`FLD_STATE]);
            end
            `OFS_OPEN_LOAD_EN: open_en_nxt = wr_data;
            `OFS_SHORT_LOAD_EN: short_en_nxt = wr_data;
            `OFS_LOAD_CONFIG: cfg_nxt = wr_data;
            default: begin
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      page_r <= `RST_PAGE;
      book_r <= `RST_BOOK;
      mod_r <= `RST_MODULATION;
      ost_r <= `RST_OUTPUT_STATE;
      pst_r <= `RST_POWER_STATE;
      state_r <= amp_ctrl_pkg::PS_DEEP_SLEEP;
      open_en_r <= `RST_LOAD_REG;
      short_en_r <= `RST_LOAD_REG;
      cfg_r <= `RST_LOAD_REG;
      strap_r <= 2'b00;
      strap_ok_r <= 1'b0;
    end else begin
      page_r <= page_nxt;
      book_r <= book_nxt;
      mod_r <= mod_nxt;
      ost_r <= ost_nxt;
      pst_r <= pst_nxt;
      state_r <= state_nxt;
      open_en_r <= open_en_nxt;
      short_en_r <= short_en_nxt;
      cfg_r <= cfg_nxt;
      strap_r <= strap_nxt;
      strap_ok_r <= strap_ok_nxt;
    end
  end

  // load detection; completion set beats a rearm in the same cycle
  logic [21:0] ld_cnt_r, ld_cnt_nxt;
  logic ld_run_r, ld_run_nxt, ld_arm;
  logic [1:0] acc_s_r, acc_s_nxt, acc_o_r, acc_o_nxt;
  logic [7:0] status_nxt;

  assign ld_arm = (open_en_r[`FLD_DETECT_EN] | short_en_r[`FLD_DETECT_EN])
    && cfg_r[`FLD_DETECT_CFG] && state_r == amp_ctrl_pkg::PS_PLAY;

  always_comb begin
    ld_cnt_nxt = ld_cnt_r;
    ld_run_nxt = ld_run_r;
    acc_s_nxt = acc_s_r;
    acc_o_nxt = acc_o_r;
    status_nxt = status_r;
    if (!pdn_ok) begin
      ld_run_nxt = 1'b0;
      status_nxt = `RST_LOAD_REG;
    end else begin
      if (ld_rearm) begin
        status_nxt[`FLD_LS_DONE] = 1'b0;
        ld_run_nxt = 1'b0;
      end else if (!ld_run_r && !status_r[`FLD_LS_DONE] && ld_arm) begin
        ld_run_nxt = 1'b1;
        ld_cnt_nxt = 22'h0;
        acc_s_nxt = 2'b00;
        acc_o_nxt = 2'b00;
      end
      if (ld_run_r) begin
        ld_cnt_nxt = ld_cnt_r + 22'h1;
        acc_s_nxt = acc_s_r | short_s;
        acc_o_nxt = acc_o_r | open_s;
        if (ld_cnt_r == LD_LAST) begin
          ld_run_nxt = 1'b0;
          status_nxt = 8'h00;
          status_nxt[`FLD_LS_DONE] = 1'b1;
          status_nxt[`FLD_LS_OPEN] = open_en_r[`FLD_DETECT_EN] ?
            (acc_o_r | open_s) : 2'b00;
          status_nxt[`FLD_LS_SHORT] = short_en_r[`FLD_DETECT_EN] ?
            (acc_s_r | short_s) : 2'b00;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ld_cnt_r <= 22'h0;
      ld_run_r <= 1'b0;
      acc_s_r <= 2'b00;
      acc_o_r <= 2'b00;
      status_r <= `RST_LOAD_REG;
    end else begin
      ld_cnt_r <= ld_cnt_nxt;
      ld_run_r <= ld_run_nxt;
      acc_s_r <= acc_s_nxt;
      acc_o_r <= acc_o_nxt;
      status_r <= status_nxt;
    end
  end

  // power domains and pwm; dsp stays alive through both sleep states
  amp_ctrl_pkg::modulation_t mod_sel;
  logic play;
  logic [7:0] pwm_cnt_r;
  logic [1:0] leg_p_nxt, leg_n_nxt;
  assign mod_sel = amp_ctrl_pkg::modulation_t'(mod_r[`FLD_MODULATION]);
  assign play = pdn_ok && state_r == amp_ctrl_pkg::PS_PLAY;

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_ch
      logic signed [7:0] lvl;
      logic [7:0] mag, dp, dn;
      logic spw;
      always_comb begin
        lvl = audio_level[8*c +: 8];
        mag = lvl[7] ? 8'(-lvl) : lvl;
        // hybrid: small signals use single-side, larger ones both-sides
        spw = (mod_sel == amp_ctrl_pkg::MOD_SINGLE_SIDE) ||
          (mod_sel == amp_ctrl_pkg::MOD_HYBRID &&
           mag < {1'b0, power_stage_supply[7:1]});
        if (spw) begin
          dp = lvl[7] ? 8'h00 : 8'(`SPW_IDLE_DUTY + mag);
          dn = (lvl[7] || lvl == 8'sh00) ?
            8'(`SPW_IDLE_DUTY + mag) : 8'h00;
          if (lvl == 8'sh00) dp = `SPW_IDLE_DUTY;
        end else begin
          dp = 8'(`PWM_MID + lvl);
          dn = 8'(`PWM_MID - lvl);
        end
        leg_p_nxt[c] = play && (pwm_cnt_r < dp);
        leg_n_nxt[c] = play && (pwm_cnt_r < dn);
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pwm_cnt_r <= 8'h00;
      positive_output_leg <= 2'b00;
      negative_output_leg <= 2'b00;
      output_stage_hiz <= 1'b1;
      digital_ldo_en <= 1'b0;
      analog_ldo_en <= 1'b0;
      dsp_active <= 1'b0;
    end else begin
      pwm_cnt_r <= pwm_cnt_r + 8'h01;
      positive_output_leg <= leg_p_nxt;
      negative_output_leg <= leg_n_nxt;
      output_stage_hiz <= !play;
      digital_ldo_en <= pdn_ok;
      analog_ldo_en <= pdn_ok &&
        state_r != amp_ctrl_pkg::PS_DEEP_SLEEP;
      dsp_active <= pdn_ok;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_addr_byte;
    st_r == amp_ctrl_pkg::I2C_ADDR && scl_rise && cnt_r == 3'h7 &&
      !start_det && !stop_det && pdn_ok;
  endsequence
  sequence s_wbyte;
    st_r == amp_ctrl_pkg::I2C_WDATA && scl_rise && cnt_r == 3'h7 &&
      !start_det && !stop_det && pdn_ok;
  endsequence

  a_addr_match_ack: assert property (s_addr_byte and
    (rx_byte[7:1] == {`TARGET_ADDR_HI, strap_r}) |=>
    st_r == amp_ctrl_pkg::I2C_ACK)
    else $error("matching address not acknowledged");
  a_addr_miss_ignore: assert property (s_addr_byte and
    (rx_byte[7:1] != {`TARGET_ADDR_HI, strap_r}) |=>
    st_r == amp_ctrl_pkg::I2C_IGNORE && !drv_r)
    else $error("foreign address not ignored");
  a_write_incr: assert property (s_wbyte |=>
    sub_r == $past(sub_r) + 8'h01)
    else $error("write did not advance subaddress");
  a_read_incr: assert property (st_r == amp_ctrl_pkg::I2C_RACK &&
    scl_rise && !start_det && !stop_det && pdn_ok |=>
    sub_r == $past(sub_r) + 8'h01)
    else $error("read did not advance subaddress");
  a_page_write: assert property (wr_en && pdn_ok &&
    wr_addr == `OFS_PAGE_SELECT |=> page_r == $past(wr_data))
    else $error("page select not taken");
  a_pdn_clear: assert property (!pdn_ok [*2] |->
    state_r == amp_ctrl_pkg::PS_DEEP_SLEEP && page_r == `RST_PAGE &&
    !digital_ldo_en && !analog_ldo_en)
    else $error("power down did not clear device");
  a_deep_analog_off: assert property (pdn_ok &&
    state_r == amp_ctrl_pkg::PS_DEEP_SLEEP |=>
    !analog_ldo_en && digital_ldo_en && dsp_active)
    else $error("deep sleep regulators wrong");
  a_sleep_analog_on: assert property (pdn_ok &&
    state_r == amp_ctrl_pkg::PS_SLEEP |=> analog_ldo_en)
    else $error("sleep lost analog regulator");
  a_hiz_legs: assert property (state_r != amp_ctrl_pkg::PS_PLAY |=>
    output_stage_hiz && positive_output_leg == 2'b00 &&
    negative_output_leg == 2'b00)
    else $error("output stage active outside play");
  a_ld_done_time: assert property ($rose(status_r[`FLD_LS_DONE]) |->
    $past(ld_cnt_r) == LD_LAST && $past(ld_run_r))
    else $error("load result flagged early");
  a_bd_idle_phase: assert property (play && mod_sel ==
    amp_ctrl_pkg::MOD_BOTH_SIDES && audio_level == 16'h0000 |=>
    positive_output_leg == negative_output_leg)
    else $error("both-sides legs not in phase at idle");

endmodule : amp_control_port_state

// file: core/pin_sync.sv
// Purpose: two-flop synchroniser for asynchronous pins plus a delay stage
// Assumes: pins are quasi-static relative to clk_sys
// Notes: pin_prev is only for edge detection downstream
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // system
  input wire logic clk_sys,
  input wire logic reset_n,
  // pins
  input wire logic [WIDTH-1:0] pin_in,
  // synchronised
  output logic [WIDTH-1:0] pin_sync,
  output logic [WIDTH-1:0] pin_prev
);

  logic [WIDTH-1:0] meta_r;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          meta_r[i] <= 1'b0;
          pin_sync[i] <= 1'b0;
          pin_prev[i] <= 1'b0;
        end else begin
          meta_r[i] <= pin_in[i];
          pin_sync[i] <= meta_r[i];
          pin_prev[i] <= pin_sync[i];
        end
      end
    end
  endgenerate

endmodule : pin_sync

// file: inc/amp_ctrl_map.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 100 MHz system clock
// Notes: all registers except page select and book select live on book 0, page 0; book select lives on page 0 of any book
`ifndef AMP_CTRL_MAP_SVH
`define AMP_CTRL_MAP_SVH

`define OFS_PAGE_SELECT 8'h00
`define OFS_MODULATION 8'h02
`define OFS_OUTPUT_STATE 8'h03
`define OFS_POWER_STATE 8'h68
`define OFS_OPEN_LOAD_EN 8'h79
`define OFS_SHORT_LOAD_EN 8'h7a
`define OFS_LOAD_CONFIG 8'h7b
`define OFS_LOAD_STATUS 8'h7c
`define OFS_BOOK_SELECT 8'h7f

`define RST_PAGE 8'h00
`define RST_BOOK 8'h00
`define RST_MODULATION 8'h00
`define RST_OUTPUT_STATE 8'h00
`define RST_POWER_STATE 8'h00
`define RST_LOAD_REG 8'h00

`define FLD_STATE 1:0
`define FLD_MODULATION 1:0
`define FLD_DETECT_EN 7
`define FLD_DETECT_CFG 0
`define FLD_LS_DONE 7
`define FLD_LS_OPEN 3:2
`define FLD_LS_SHORT 1:0

`define TARGET_ADDR_HI 5'h15

`define PWM_MID 8'h80
`define SPW_IDLE_DUTY 8'h2c

`define CLK_PERIOD_NS 10
`define LOAD_DETECT_TIME_US 20000
`define LOAD_DETECT_CYCLES (`LOAD_DETECT_TIME_US * 1000 / `CLK_PERIOD_NS)

`endif

// file: inc/amp_ctrl_pkg.sv
// Purpose: types shared by the control port and state logic
// Assumes: nothing
// Notes: enum order gives the two-bit and three-bit codes
package amp_ctrl_pkg;

  typedef enum logic [1:0] {
    PS_DEEP_SLEEP,
    PS_SLEEP,
    PS_OUTPUT_HIZ,
    PS_PLAY
  } power_state_t;

  typedef enum logic [1:0] {
    MOD_BOTH_SIDES,
    MOD_SINGLE_SIDE,
    MOD_HYBRID,
    MOD_SPARE
  } modulation_t;

  typedef enum logic [2:0] {
    I2C_IDLE,
    I2C_ADDR,
    I2C_SUB,
    I2C_WDATA,
    I2C_ACK,
    I2C_RDATA,
    I2C_RACK,
    I2C_IGNORE
  } i2c_state_t;

endpackage : amp_ctrl_pkg

// file: testbench/amp_control_port_state_bench.sv
// Purpose: self-checking bench for the control port and state logic
// Assumes: strap decoded to 01, so the target address is 0x55
// Notes: load detect shortened to 50 cycles
`timescale 1ns/10ps
`include "amp_ctrl_map.svh"
module amp_control_port_state_bench;
  localparam logic [6:0] ADDR = 7'h55;
  logic clk_sys, reset_n, power_down_pin_n, scl, sda_low, sda_out;
  logic sda_oe_n, digital_ldo_en, analog_ldo_en, dsp_active, ok;
  logic output_stage_hiz;
  logic [1:0] addr_strap, load_short_flag, load_open_flag, pos_leg, neg_leg;
  logic [15:0] level;
  logic [7:0] q[$];
  int errors, comparisons;
  wire sda_line = ~(sda_low | (~sda_oe_n & ~sda_out));
  amp_control_port_state #(.LOAD_DETECT_CYCLES(50)) dut (
    .clk_sys(clk_sys), .reset_n(reset_n),
    .power_down_pin_n(power_down_pin_n), .addr_strap(addr_strap),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .load_short_flag(load_short_flag),
    .load_open_flag(load_open_flag), .audio_level(level),
    .power_stage_supply(8'h40), .digital_ldo_en(digital_ldo_en),
    .analog_ldo_en(analog_ldo_en), .dsp_active(dsp_active),
    .output_stage_hiz(output_stage_hiz), .positive_output_leg(pos_leg),
    .negative_output_leg(neg_leg));
  i2c_host_model host (.clk_sys(clk_sys), .sda_line(sda_line),
    .scl(scl), .sda_low(sda_low));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t byte %h expected %h", $time, got, exp);
    end
  endtask : check_byte
  task automatic check_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask : check_bit
  task automatic check_count(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : check_count
  // one full pwm period, so the counter phase does not matter
  task automatic count_legs(output logic [8:0] p, output logic [8:0] n,
                            output logic [8:0] odd);
    p = 9'h000;
    n = 9'h000;
    odd = 9'h000;
    repeat (256) begin
      @(posedge clk_sys);
      #1;
      p = p + 9'(pos_leg[0]);
      n = n + 9'(neg_leg[0]);
      odd = odd + 9'(pos_leg[0] != neg_leg[0]);
    end
  endtask : count_legs
  task automatic expect_reg(input logic [7:0] sub, input logic [7:0] exp);
    host.rd(ADDR, sub, 1, q);
    check_byte(q[0], exp);
  endtask : expect_reg
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic t_address();
    host.wr(7'h56, 8'h02, '{8'h02}, ok);
    check_bit(ok, 1'b0);
    expect_reg(8'h02, 8'h00);
  endtask : t_address
  // sequential write across 0x02 and output_state_control, then sequential read back
  task automatic t_sequential();
    host.wr(ADDR, 8'h02, '{8'h01, 8'h0f}, ok);
    check_bit(ok, 1'b1);
    host.rd(ADDR, 8'h02, 2, q);
    check_byte(q[0], 8'h01);
    check_byte(q[1], 8'h0f);
    check_bit(output_stage_hiz, 1'b0);
  endtask : t_sequential
  task automatic t_states();
    for (int c = 0; c < 4; c++) begin
      host.wr(ADDR, 8'h68, '{8'(c)}, ok);
      check_bit(output_stage_hiz, c != 3);
      check_bit(analog_ldo_en, c != 0);
      check_bit(dsp_active, 1'b1);
    end
    host.wr(ADDR, 8'h68, '{8'h00}, ok);
    expect_reg(8'h02, 8'h01);
  endtask : t_states
  task automatic t_page();
    host.wr(ADDR, 8'h00, '{8'h05}, ok);
    expect_reg(8'h02, 8'h00);
    expect_reg(8'h00, 8'h05);
    host.wr(ADDR, 8'h00, '{8'h00}, ok);
    host.wr(ADDR, 8'h7f, '{8'h8c}, ok);
    expect_reg(8'h02, 8'h00);
    expect_reg(8'h7f, 8'h8c);
    host.wr(ADDR, 8'h7f, '{8'h00}, ok);
    expect_reg(8'h02, 8'h01);
  endtask : t_page
  // hybrid entry; the long host waits are scaled down for simulation
  task automatic t_modulation();
    logic [8:0] p, n, odd;
    level = 16'h0010;
    host.wr(ADDR, 8'h02, '{8'h00}, ok);
    host.wr(ADDR, 8'h03, '{8'h02}, ok);
    check_bit(output_stage_hiz, 1'b1);
    check_bit(analog_ldo_en, 1'b1);
    repeat (20) @(posedge clk_sys);
    host.wr(ADDR, 8'h02, '{8'h02}, ok);
    repeat (150) @(posedge clk_sys);
    host.wr(ADDR, 8'h03, '{8'h03}, ok);
    check_bit(output_stage_hiz, 1'b0);
    expect_reg(8'h02, 8'h02);
    count_legs(p, n, odd);
    check_count(p, 9'(`SPW_IDLE_DUTY) + 9'h010);
    check_count(n, 9'h000);
    level = 16'h0000;
    host.wr(ADDR, 8'h02, '{8'h00}, ok);
    count_legs(p, n, odd);
    check_count(p, 9'(`PWM_MID));
    check_count(odd, 9'h000);
  endtask : t_modulation
  task automatic t_load();
    load_short_flag = 2'b10;
    host.wr(ADDR, 8'h03, '{8'h0f}, ok);
    host.wr(ADDR, 8'h7b, '{8'h03}, ok);
    host.wr(ADDR, 8'h7a, '{8'hc9}, ok);
    repeat (80) @(posedge clk_sys);
    expect_reg(8'h7c, 8'h82);
    load_short_flag = 2'b00;
    load_open_flag = 2'b01;
    host.wr(ADDR, 8'h7b, '{8'h09}, ok);
    host.wr(ADDR, 8'h79, '{8'hc0}, ok);
    repeat (80) @(posedge clk_sys);
    expect_reg(8'h7c, 8'h84);
  endtask : t_load
  task automatic t_power_down();
    power_down_pin_n = 1'b0;
    repeat (8) @(posedge clk_sys);
    check_bit(digital_ldo_en, 1'b0);
    check_bit(analog_ldo_en, 1'b0);
    #1 power_down_pin_n = 1'b1;
    repeat (20) @(posedge clk_sys);
    expect_reg(8'h02, 8'h00);
    expect_reg(8'h03, 8'h00);
  endtask : t_power_down
  initial begin
    errors = 0;
    comparisons = 0;
    reset_n = 1'b0;
    power_down_pin_n = 1'b1;
    addr_strap = 2'b01;
    load_short_flag = 2'b00;
    load_open_flag = 2'b00;
    level = 16'h0000;
    repeat (12) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    repeat (20) @(posedge clk_sys);
    check_bit(digital_ldo_en, 1'b1);
    check_bit(analog_ldo_en, 1'b0);
    expect_reg(8'h68, 8'h00);
    t_address();
    t_sequential();
    t_states();
    t_page();
    t_modulation();
    t_load();
    t_power_down();
    end_of_test();
  end
  // whole run needs about 16k cycles, well under the 40k-cycle limit
  initial begin
    #400000;
    errors++;
    end_of_test();
  end
endmodule : amp_control_port_state_bench

// file: testbench/i2c_host_model.sv
// Purpose: i2c bus controller standing in for the host
// Assumes: bench resolves the open-drain sda with a pull-up
// Notes: each scl phase lasts Q clocks, above the 4 the port needs
`timescale 1ns/10ps
module i2c_host_model (
  // system
  input wire logic clk_sys,
  // bus
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  localparam int Q = 6;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick();
    repeat (Q) @(posedge clk_sys);
    #1;
  endtask : tick
  // also used as repeated start
  task automatic start();
    sda_low = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    sda_low = 1'b1;
    tick();
    scl = 1'b0;
    tick();
  endtask : start
  task automatic stop();
    sda_low = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    sda_low = 1'b0;
    tick();
  endtask : stop
  // data held through the high phase, changed only after scl is low
  task automatic xfer(input logic [7:0] d, input logic b9,
                      output logic [7:0] q, output logic ack);
    logic [8:0] s;
    logic [8:0] r;
    s = {d, b9};
    r = '0;
    for (int i = 0; i < 9; i++) begin
      sda_low = ~s[8];
      s = s << 1;
      tick();
      scl = 1'b1;
      tick();
      r = {r[7:0], sda_line};
      scl = 1'b0;
    end
    tick();
    q = r[8:1];
    ack = ~r[0];
  endtask : xfer
  task automatic wr(input logic [6:0] a, input logic [7:0] sub,
                    input logic [7:0] d[$], output logic ok);
    logic [7:0] q;
    logic k;
    start();
    xfer({a, 1'b0}, 1'b1, q, ok);
    if (ok) begin
      xfer(sub, 1'b1, q, k);
      ok = ok & k;
      foreach (d[i]) begin
        xfer(d[i], 1'b1, q, k);
        ok = ok & k;
      end
    end
    stop();
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] sub,
                    input int n, output logic [7:0] v[$]);
    logic [7:0] q;
    logic k;
    v = {};
    start();
    xfer({a, 1'b0}, 1'b1, q, k);
    xfer(sub, 1'b1, q, k);
    start();
    xfer({a, 1'b1}, 1'b1, q, k);
    for (int i = 0; i < n; i++) begin
      xfer(8'hff, i == n - 1, q, k);
      v.push_back(q);
    end
    stop();
  endtask : rd
endmodule : i2c_host_model
